// [core/spd_pkg.sv]
// Package of constants, layouts and lookups for the SPI DMA control engine
package spd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
    localparam logic [4:0] OFF_CTRL_TWO = 5'h04;
    localparam logic [4:0] OFF_TX_PTR   = 5'h08;
    localparam logic [4:0] OFF_RX_PTR   = 5'h0c;
    localparam logic [4:0] OFF_COUNT    = 5'h10;
    localparam logic [4:0] OFF_STATUS   = 5'h14;
    localparam logic [4:0] OFF_CONFIG   = 5'h18;

    ////////////////////////////////////////////////////////////////////////
    // Widths and reset values
    localparam int PTR_W = 12;
    localparam int CNT_W = 10;
    localparam int GAP_W = 12;
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [2:0] CONFIG_RST   = 3'h0;

    // Status and config bit positions
    localparam int ST_IRQ_BIT  = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_CS_BIT   = 2;
    localparam int CF_MST_BIT  = 0;
    localparam int CF_DIV_LSB  = 1;

    ////////////////////////////////////////////////////////////////////////
    // Field encodings
    localparam logic [1:0] CS_OFF  = 2'h0;
    localparam logic [1:0] CS_TWO  = 2'h1;
    localparam logic [1:0] CS_ONE  = 2'h2;
    localparam logic [1:0] CS_FOUR = 2'h3;
    localparam logic [1:0] DIR_RX   = 2'h0;
    localparam logic [1:0] DIR_TX   = 2'h1;
    localparam logic [1:0] DIR_FULL = 2'h2;
    localparam logic [1:0] DIV_4  = 2'h0;
    localparam logic [1:0] DIV_16 = 2'h1;

    // Least idle cycles between master bytes per serial clock divide
    localparam logic [GAP_W-1:0] BASE_DIV4  = 12'h008;
    localparam logic [GAP_W-1:0] BASE_DIV16 = 12'h009;
    localparam logic [GAP_W-1:0] BASE_DIV64 = 12'h00f;

    ////////////////////////////////////////////////////////////////////////
    // Layouts
    typedef struct packed {
        logic [1:0] csGroupSel;
        logic       txPointerStepEn;
        logic       rxPointerStepEn;
        logic [1:0] directionSel;
        logic       gapIrqEnable;
        logic       transferRun;
    } spd_ctrl_one_type;

    typedef struct packed {
        logic [3:0] gapCycleSelect;
        logic [3:0] watermarkSelect;
    } spd_ctrl_two_type;

    typedef struct packed {
        logic             req;
        logic             write;
        logic [PTR_W-1:0] addr;
        logic [7:0]       wdata;
    } spd_mem_req_type;

    ////////////////////////////////////////////////////////////////////////
    // Gap cycles: powers of two, then steps of 128, then 1024 and 2048
    function automatic logic [GAP_W-1:0] gapCycles(input logic [3:0] sel);
        logic [GAP_W-1:0] v;
        v = 12'h000;
        if (sel < 4'h8)
            v = 12'h001 << sel;
        else if (sel < 4'he)
            v = {1'b0, 4'(sel - 4'h6), 7'h00};
        else if (sel == 4'he)
            v = 12'h400;
        else
            v = 12'h800;
        return v;
    endfunction

    // Watermark in remaining bytes; zero means completion only
    function automatic logic [CNT_W:0] markBytes(input logic [3:0] sel);
        logic [CNT_W:0] v;
        v = 11'h000;
        if (sel == 4'h0)
            v = 11'h000;
        else if (sel < 4'h7)
            v = 11'h001 << (sel - 4'h1);
        else if (sel == 4'h7)
            v = 11'h043;
        else
            v = {1'b0, 4'(sel - 4'h6), 6'h00};
        return v;
    endfunction

endpackage

// [core/spd_ctrl.sv]
// Control logic of the SPI DMA engine: registers, sequencer, pacing, flag
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps

module spd_ctrl (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]                address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic      [31:0]               readdata,
    output logic                           waitrequest,
    // Serial shifter
    output logic                           masterMode,
    output logic      [1:0]                sclkDivSel,
    output logic                           byteLoad,
    output logic      [7:0]                txByte,
    input  wire logic                      shiftBusy,
    input  wire logic                      shiftDone,
    input  wire logic [7:0]                rxByte,
    // SRAM port
    output spd_pkg::spd_mem_req_type       memReq,
    input  wire logic                      memAck,
    input  wire logic [7:0]                memRdata,
    // Pins and flag
    output logic                           engineChipSelectOut_n,
    output logic                           portIrqFlag
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_LOAD, ST_SHIFT, ST_STORE, ST_GAP
    } spd_state_type;

    spd_pkg::spd_ctrl_one_type       ctrlOne;
    spd_pkg::spd_ctrl_two_type       ctrlTwo;
    logic [2:0]                      modeCfg;
    logic [spd_pkg::PTR_W-1:0]       txSourcePointer;
    logic [spd_pkg::PTR_W-1:0]       rxDestPointer;
    logic [spd_pkg::CNT_W-1:0]       remainingByteCounter;
    spd_state_type                   state;
    logic [7:0]                      rxData;
    logic [spd_pkg::GAP_W-1:0]       gapCnt;
    logic [spd_pkg::GAP_W-1:0]       idleCnt;
    logic                            toFired;
    logic                            markPrev;
    logic [1:0]                      groupCnt;
    logic                            csActive;
    logic                            rdValid;
    logic [31:0]                     next_readdata;

    ////////////////////////////////////////////////////////////////////////
    // Decode and derived controls
    logic                            run;
    logic                            busy;
    logic                            isTx;
    logic                            isRx;
    logic                            wrLo;
    logic                            wrHi;
    logic                            byteFinish;
    logic                            lastByte;
    logic                            doneEvt;
    logic                            abortEvt;
    logic                            markHit;
    logic                            toEvt;
    logic [spd_pkg::GAP_W-1:0]       gapSel;
    logic [spd_pkg::GAP_W-1:0]       baseGap;
    logic [spd_pkg::GAP_W-1:0]       gapLoad;
    logic [spd_pkg::CNT_W:0]         remaining;
    logic [1:0]                      groupLast;

    assign run        = ctrlOne.transferRun;
    assign busy       = (state != ST_IDLE);
    assign masterMode = modeCfg[spd_pkg::CF_MST_BIT];
    assign sclkDivSel = modeCfg[spd_pkg::CF_DIV_LSB +: 2];
    assign wrLo       = write && byteenable[0];
    assign wrHi       = write && byteenable[1];
    // Code 11 is not defined; it behaves as receive only
    assign isTx = (ctrlOne.directionSel == spd_pkg::DIR_TX) ||
                  (ctrlOne.directionSel == spd_pkg::DIR_FULL);
    assign isRx = (ctrlOne.directionSel != spd_pkg::DIR_TX);

    assign lastByte = (remainingByteCounter == '0);
    assign byteFinish = (state == ST_SHIFT && shiftDone && run && !isRx) ||
                        (state == ST_STORE && memAck);
    assign doneEvt  = byteFinish && lastByte;
    // Abort only once no byte is on the wire
    assign abortEvt = !run && (state == ST_FETCH || state == ST_LOAD ||
                      state == ST_GAP ||
                      (state == ST_SHIFT && !shiftBusy));

    assign gapSel = spd_pkg::gapCycles(ctrlTwo.gapCycleSelect);
    always_comb begin
        case (sclkDivSel)
            spd_pkg::DIV_4:  baseGap = spd_pkg::BASE_DIV4;
            spd_pkg::DIV_16: baseGap = spd_pkg::BASE_DIV16;
            default:         baseGap = spd_pkg::BASE_DIV64;
        endcase
    end
    // Gap irq drops the added delay, leaving only base overhead
    assign gapLoad = ctrlOne.gapIrqEnable ? baseGap - 12'h001
                                          : baseGap + gapSel - 12'h001;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: writes take one cycle, reads one wait state
    assign waitrequest = read && !rdValid;

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            spd_pkg::OFF_CTRL_ONE: next_readdata[7:0] = ctrlOne;
            spd_pkg::OFF_CTRL_TWO: next_readdata[7:0] = ctrlTwo;
            spd_pkg::OFF_TX_PTR:
                next_readdata[spd_pkg::PTR_W-1:0] = txSourcePointer;
            spd_pkg::OFF_RX_PTR:
                next_readdata[spd_pkg::PTR_W-1:0] = rxDestPointer;
            spd_pkg::OFF_COUNT:
                next_readdata[spd_pkg::CNT_W-1:0] = remainingByteCounter;
            spd_pkg::OFF_STATUS: begin
                next_readdata[spd_pkg::ST_IRQ_BIT]  = portIrqFlag;
                next_readdata[spd_pkg::ST_BUSY_BIT] = busy;
                next_readdata[spd_pkg::ST_CS_BIT]   = csActive;
            end
            spd_pkg::OFF_CONFIG: next_readdata[2:0] = modeCfg;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdValid  <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            rdValid <= read && !rdValid;
            if (read && !rdValid)
                readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlOne <= spd_pkg::CTRL_ONE_RST;
        end else begin
            if (wrLo && address == spd_pkg::OFF_CTRL_ONE) begin
                ctrlOne <= writedata[7:0];
                if (writedata[7:6] != spd_pkg::CS_OFF)
                    ctrlOne.gapIrqEnable <= 1'b0;
            end
            if (doneEvt)
                ctrlOne.transferRun <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlTwo <= spd_pkg::CTRL_TWO_RST;
            modeCfg <= spd_pkg::CONFIG_RST;
        end else begin
            if (wrLo && address == spd_pkg::OFF_CTRL_TWO)
                ctrlTwo <= writedata[7:0];
            // Mode changes are locked out while the sequencer runs
            if (wrLo && address == spd_pkg::OFF_CONFIG && !busy && !run)
                modeCfg <= writedata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers and byte counter; software loads them only while idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txSourcePointer <= '0;
        end else if (!busy && !run && address == spd_pkg::OFF_TX_PTR) begin
            if (wrLo)
                txSourcePointer[7:0] <= writedata[7:0];
            if (wrHi)
                txSourcePointer[11:8] <= writedata[11:8];
        end else if (state == ST_FETCH && memAck && run &&
                     ctrlOne.txPointerStepEn) begin
            txSourcePointer <= txSourcePointer + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxDestPointer <= '0;
        end else if (!busy && !run && address == spd_pkg::OFF_RX_PTR) begin
            if (wrLo)
                rxDestPointer[7:0] <= writedata[7:0];
            if (wrHi)
                rxDestPointer[11:8] <= writedata[11:8];
        end else if (state == ST_STORE && memAck &&
                     ctrlOne.rxPointerStepEn) begin
            rxDestPointer <= rxDestPointer + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            remainingByteCounter <= '0;
        end else if (!busy && !run && address == spd_pkg::OFF_COUNT) begin
            if (wrLo)
                remainingByteCounter[7:0] <= writedata[7:0];
            if (wrHi)
                remainingByteCounter[9:8] <= writedata[9:8];
        end else if (byteFinish && !lastByte) begin
            remainingByteCounter <= remainingByteCounter - 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE:
                    if (run)
                        state <= isTx ? ST_FETCH : ST_LOAD;
                ST_FETCH:
                    if (abortEvt)
                        state <= ST_IDLE;
                    else if (memAck)
                        state <= ST_LOAD;
                ST_LOAD:
                    if (abortEvt)
                        state <= ST_IDLE;
                    else
                        state <= ST_SHIFT;
                ST_SHIFT:
                    if (shiftDone) begin
                        if (!run)
                            state <= ST_IDLE;
                        else if (isRx)
                            state <= ST_STORE;
                        else if (lastByte)
                            state <= ST_IDLE;
                        else if (masterMode)
                            state <= ST_GAP;
                        else
                            state <= ST_FETCH;
                    end else if (abortEvt) begin
                        state <= ST_IDLE;
                    end
                ST_STORE:
                    if (memAck) begin
                        if (lastByte || !run)
                            state <= ST_IDLE;
                        else if (masterMode)
                            state <= ST_GAP;
                        else
                            state <= isTx ? ST_FETCH : ST_LOAD;
                    end
                ST_GAP:
                    if (abortEvt)
                        state <= ST_IDLE;
                    else if (gapCnt == '0)
                        state <= isTx ? ST_FETCH : ST_LOAD;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // One pulse per byte; shifter starts at once as master, waits as slave
    assign byteLoad = (state == ST_LOAD) && run;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txByte <= 8'h00;
            rxData <= 8'h00;
        end else begin
            if (state == ST_FETCH && memAck)
                txByte <= memRdata;
            else if (state == ST_IDLE && run && !isTx)
                txByte <= 8'hff;
            if (state == ST_SHIFT && shiftDone)
                rxData <= rxByte;
        end
    end

    // Requests only exist in fetch and store states, so none after abort
    always_comb begin
        memReq.req   = (state == ST_FETCH && run) ||
                       (state == ST_STORE);
        memReq.write = (state == ST_STORE);
        memReq.addr  = (state == ST_STORE) ? rxDestPointer
                                           : txSourcePointer;
        memReq.wdata = rxData;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            gapCnt <= '0;
        else if (byteFinish && !lastByte)
            gapCnt <= gapLoad;
        else if (state == ST_GAP && gapCnt != '0)
            gapCnt <= gapCnt - 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip select groups in master mode
    always_comb begin
        case (ctrlOne.csGroupSel)
            spd_pkg::CS_FOUR: groupLast = 2'h3;
            spd_pkg::CS_TWO:  groupLast = 2'h1;
            default:          groupLast = 2'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csActive <= 1'b0;
            groupCnt <= 2'h0;
        end else if (state == ST_IDLE || !masterMode ||
                     ctrlOne.csGroupSel == spd_pkg::CS_OFF) begin
            csActive <= 1'b0;
            groupCnt <= 2'h0;
        end else if (byteFinish) begin
            if (groupCnt == groupLast || lastByte) begin
                csActive <= 1'b0;
                groupCnt <= 2'h0;
            end else begin
                groupCnt <= groupCnt + 2'h1;
            end
        end else if ((state == ST_FETCH || state == ST_LOAD) && run) begin
            csActive <= 1'b1;
        end
    end

    assign engineChipSelectOut_n = !csActive;

    ////////////////////////////////////////////////////////////////////////
    // Inactivity time-out, live while transferRun is set with gap irq enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idleCnt <= '0;
            toFired <= 1'b0;
        end else if (!run || !ctrlOne.gapIrqEnable || shiftDone) begin
            idleCnt <= '0;
            toFired <= 1'b0;
        end else if (!toFired) begin
            if (idleCnt == gapSel)
                toFired <= 1'b1;
            else
                idleCnt <= idleCnt + 12'h001;
        end
    end

    assign toEvt = run && ctrlOne.gapIrqEnable && !shiftDone &&
                   !toFired && (idleCnt == gapSel);

    ////////////////////////////////////////////////////////////////////////
    // Watermark and port flag
    assign remaining = {1'b0, remainingByteCounter} + 11'h001;
    assign markHit = run && (spd_pkg::markBytes(ctrlTwo.watermarkSelect)
                     != '0) &&
                     (remaining <= spd_pkg::markBytes(ctrlTwo.watermarkSelect));

    always_ff @(posedge clk) begin
        if (!rst_n)
            markPrev <= 1'b0;
        else
            markPrev <= markHit;
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n)
            portIrqFlag <= 1'b0;
        else if ((markHit && !markPrev) || toEvt || doneEvt)
            portIrqFlag <= 1'b1;
        else if (wrLo && address == spd_pkg::OFF_STATUS &&
                 writedata[spd_pkg::ST_IRQ_BIT])
            portIrqFlag <= 1'b0;
    end

endmodule

// [verif/spd_ctrl_asserts.sv]
// Port assertions for the SPI DMA control block
`timescale 1ns/100ps
module spd_ctrl_asserts (
    input wire logic                clk, rst_n, read, write, waitrequest,
    input wire logic                masterMode, byteLoad, shiftDone, memAck,
    input wire logic                engineChipSelectOut_n, portIrqFlag,
    input wire logic [4:0]          address,
    input wire logic [31:0]         writedata,
    input spd_pkg::spd_mem_req_type memReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_fetch_ack;
        memReq.req && !memReq.write && memAck;
    endsequence
    sequence s_one_load;
        byteLoad ##1 !byteLoad;
    endsequence
    a_read_first: assert property (read && !$past(read) |-> waitrequest)
        else $error("read not held off");
    a_read_answer: assert property (read && waitrequest |=> !waitrequest)
        else $error("read answer late");
    a_write_nowait: assert property (write |-> !waitrequest)
        else $error("write stalled");
    a_fetch_load: assert property (s_fetch_ack |=> s_one_load)
        else $error("no load after fetch");
    a_req_hold: assert property (memReq.req && !memAck |=>
        memReq.req && $stable(memReq.addr)) else $error("request dropped");
    a_master_gap: assert property (masterMode && shiftDone |=>
        !byteLoad [*8]) else $error("gap too short");
    a_flag_sticky: assert property (portIrqFlag && !(write &&
        writedata[0] && address == spd_pkg::OFF_STATUS) |=> portIrqFlag)
        else $error("flag lost");
    a_slave_cs: assert property (!masterMode |-> engineChipSelectOut_n)
        else $error("select driven in slave");
endmodule
////////////////////////////////////////////////////////////////////////////
bind spd_ctrl spd_ctrl_asserts chk (.clk, .rst_n, .read, .write,
    .waitrequest, .masterMode, .byteLoad, .shiftDone, .memAck,
    .engineChipSelectOut_n, .portIrqFlag, .address, .writedata, .memReq);

// [verif/spd_link_model.sv]
// Behavioural serial shifter and SRAM facing the engine
`timescale 1ns/100ps
module spd_link_model (
    // Engine side, plus the lag setting from the bench
    input  wire logic                clk, rst_n, byteLoad,
    input  spd_pkg::spd_mem_req_type memReq,
    input  wire logic [3:0]          lag,
    // Answers
    output logic                     shiftBusy, shiftDone, memAck,
    output logic [7:0]               rxByte, memRdata
);
    logic [7:0] mem [4096];
    logic [7:0] rxCnt;
    logic [4:0] sh;
    logic [3:0] mw;
    assign shiftBusy = sh != 5'h00;
    // Lag stands for a slow far-side master clocking the byte
    always_ff @(posedge clk) begin
        shiftDone <= 1'b0;
        if (!rst_n) begin
            sh <= 5'h00;
            rxCnt <= 8'h00;
            rxByte <= 8'h00;
        end else if (byteLoad) begin
            sh <= 5'h08 + 5'(lag);
        end else if (sh == 5'h01) begin
            sh <= 5'h00;
            shiftDone <= 1'b1;
            rxByte <= rxCnt ^ 8'ha5;
            rxCnt <= rxCnt + 8'h01;
        end else begin
            sh <= sh - 5'(shiftBusy);
            rxByte <= ~rxByte;
        end
    end
    // Plain always: the bench preloads the array
    always @(posedge clk) begin
        memAck <= 1'b0;
        if (!rst_n) begin
            mw <= 4'h0;
        end else if (memReq.req && !memAck) begin
            mw <= mw + 4'h1;
            if (mw == lag) begin
                mw <= 4'h0;
                memAck <= 1'b1;
                if (memReq.write) mem[memReq.addr] <= memReq.wdata;
                else memRdata <= mem[memReq.addr];
            end
        end else memRdata <= ~memRdata;
    end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the SPI DMA control block
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [3:0]  lag = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, seed = 32'hf19ecafc;
    logic        waitrequest, masterMode, byteLoad, shiftBusy, shiftDone;
    logic        memAck, engineChipSelectOut_n, portIrqFlag, csPrev = 1'b1;
    logic [1:0]  sclkDivSel;
    logic [7:0]  txByte, rxByte, memRdata, txLog [$];
    spd_pkg::spd_mem_req_type memReq;
    int miscompares = 0, check_count = 0, loads, csFalls, minGap, cyc, last;
    always #2.5 clk = ~clk;
    spd_ctrl uut (.clk, .rst_n, .address, .read, .write, .writedata,
        .byteenable(4'hf), .readdata, .waitrequest, .masterMode,
        .sclkDivSel, .byteLoad, .txByte, .shiftBusy, .shiftDone, .rxByte,
        .memReq, .memAck, .memRdata, .engineChipSelectOut_n, .portIrqFlag);
    spd_link_model lm (.clk, .rst_n, .byteLoad, .memReq, .lag, .shiftBusy,
        .shiftDone, .memAck, .rxByte, .memRdata);
    always @(posedge clk) begin
        cyc++;
        if (shiftDone === 1'b1) last = cyc;
        if (byteLoad === 1'b1) begin
            if (loads > 0 && cyc - last < minGap) minGap = cyc - last;
            loads++;
            txLog.push_back(txByte);
        end
        if (csPrev === 1'b1 && engineChipSelectOut_n === 1'b0) csFalls++;
        csPrev = engineChipSelectOut_n;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int gapOf(input int s, input int d);
        int b;
        b = d == 0 ? 8 : d == 1 ? 9 : 15;
        if (s < 8) return b + (1 << s);
        return b + (s < 14 ? (s - 6) * 128 : s == 14 ? 1024 : 2048);
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic [7:0] c, input logic [3:0] g,
                        input logic [2:0] cf, input int n, input bit ab);
        logic [31:0] d;
        logic [11:0] tb, rb;
        logic [7:0]  rc;
        logic        tm, rm;
        int nd, gr;
        tb = {1'b0, 11'(rnd())};
        rb = {1'b1, 11'(rnd())};
        rc = lm.rxCnt;
        tm = c[3:2] == spd_pkg::DIR_TX || c[3:2] == spd_pkg::DIR_FULL;
        rm = c[3:2] != spd_pkg::DIR_TX;
        wr(spd_pkg::OFF_STATUS, 32'h1);
        wr(spd_pkg::OFF_CONFIG, 32'(cf));
        wr(spd_pkg::OFF_TX_PTR, 32'(tb));
        wr(spd_pkg::OFF_RX_PTR, 32'(rb));
        wr(spd_pkg::OFF_COUNT, 32'(n - 1));
        wr(spd_pkg::OFF_CTRL_TWO, {24'h0, g, 4'h0});
        chk({masterMode, sclkDivSel}, {cf[0], cf[2:1]});
        loads = 0; csFalls = 0; minGap = 99999; txLog.delete();
        wr(spd_pkg::OFF_CTRL_ONE, {24'h0, c});
        rd(spd_pkg::OFF_STATUS, d);
        chk(d[1], 1'b1);
        // Time-out needs idle cycles first, so look again
        rd(spd_pkg::OFF_STATUS, d);
        chk(d[1:0], {1'b1, c[1]});
        if (ab) begin
            while (shiftBusy !== 1'b1) @(posedge clk);
            wr(spd_pkg::OFF_CTRL_ONE, {24'h0, c[7:1], 1'b0});
        end
        do rd(spd_pkg::OFF_STATUS, d); while (d[1] !== 1'b0);
        if (!ab) chk(d[0], 1'b1);
        nd = ab ? 0 : n;
        chk(32'(loads), ab ? 1 : n);
        rd(spd_pkg::OFF_CTRL_ONE, d);
        chk(d[0], 1'b0);
        rd(spd_pkg::OFF_COUNT, d);
        chk(d[9:0], ab ? 10'(n - 1) : 10'h0);
        rd(spd_pkg::OFF_TX_PTR, d);
        chk(d[11:0], tb + (tm && c[5] ? 12'(loads) : 12'h0));
        foreach (txLog[i])
            chk(txLog[i], tm ? lm.mem[tb + (c[5] ? 12'(i) : 12'h0)] : 8'hff);
        rd(spd_pkg::OFF_RX_PTR, d);
        chk(d[11:0], rb + (rm && c[4] ? 12'(nd) : 12'h0));
        for (int i = 0; i < nd && rm; i++)
            if (c[4] || i == nd - 1)
                chk(lm.mem[rb + (c[4] ? 12'(i) : 12'h0)], (rc + 8'(i)) ^ 8'ha5);
        gr = c[7:6] == spd_pkg::CS_FOUR ? 4 : c[7:6] == spd_pkg::CS_TWO ? 2 : 1;
        chk(csFalls, cf[0] && c[7:6] != 2'h0 ? (n + gr - 1) / gr : 0);
        chk(engineChipSelectOut_n, 1'b1);
        if (cf[0] && n > 1) chk(minGap >= gapOf(g, cf[2:1]), 1'b1);
    endtask
    initial begin
        logic [31:0] d;
        logic [7:0]  c;
        for (int i = 0; i < 4096; i++) lm.mem[i] = 8'(rnd());
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(spd_pkg::OFF_CTRL_ONE, d);
        chk(d, 32'h0);
        rd(5'h1c, d);
        chk(d, 32'h0);
        wr(spd_pkg::OFF_CTRL_ONE, 32'h42);
        rd(spd_pkg::OFF_CTRL_ONE, d);
        chk(d, 32'h40);
        wr(spd_pkg::OFF_CTRL_ONE, 32'h02);
        rd(spd_pkg::OFF_CTRL_ONE, d);
        chk(d, 32'h02);
        wr(spd_pkg::OFF_CTRL_ONE, 32'h00);
        for (int i = 0; i < 8; i++) begin
            c = (8'(rnd()) & 8'hf0) | 8'(i % 3 << 2) | 8'h01;
            if (i % 2 == 0) c[7:6] = 2'h0;
            lag <= 4'(rnd());
            xfer(c, i % 2 ? 4'(rnd() % 4) : 4'h0, {2'(rnd() % 3), i % 2 == 1},
                 i == 7 ? 1 : 1 + int'(rnd() % 5), 1'b0);
        end
        lag <= 4'hf;
        xfer(8'h03, 4'h0, 3'h0, 1, 1'b0);
        xfer(8'h11, 4'h0, 3'h0, 4, 1'b1);
        xfer(8'h05, 4'hf, 3'h5, 2, 1'b0);
        final_report();
    end
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule
